// [design/audio_adc_gpio_value_monitor.sv]
`timescale 1ns/100ps
module audio_adc_gpio_value_monitor (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpio_monitor_pkg::ADDR_W-1:0] paddr,
  input wire logic [gpio_monitor_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [gpio_monitor_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic multiPinIn,
  output logic multiPinOut,
  output logic multiPinOe,
  output logic outputPinOut,
  output logic outputPinOe,
  input wire logic sharedAnalogInPin,
  input wire logic micBiasPinIn,
  output logic masterClockIn,
  output logic serialAudioChainInput,
  output logic pdmDataInCh12,
  output logic pdmDataInCh34,
  output logic channelPowerDown,
  output logic micBiasEnable
);
  // software-visible state
  logic [3:0] multiPinFunction;
  logic [3:0] outputPinFunction;
  logic multiPinOutLevel;
  logic outputPinOutLevel;
  logic [2:0] firstInputPinFunction;
  logic [2:0] secondInputPinFunction;
  logic multiPinInLevel;
  logic firstInputPinLevel;
  logic secondInputPinLevel;

  // synchronised pin levels
  logic [gpio_monitor_pkg::PIN_COUNT-1:0] pinRaw;
  logic [gpio_monitor_pkg::PIN_COUNT-1:0] pinLevel;

  // bus decode
  logic [7:0] regIndex;
  logic aligned;
  logic mapped;
  logic setupPhase;
  logic accessDone;
  logic writeLow;
  logic [gpio_monitor_pkg::REG_W-1:0] wbyte;
  logic [gpio_monitor_pkg::REG_W-1:0] readByte;

  // routed function levels
  logic next_masterClockIn;
  logic next_serialAudioChainInput;
  logic next_pdmDataInCh12;
  logic next_pdmDataInCh34;
  logic next_channelPowerDown;
  logic next_micBiasEnable;

  // true when the index belongs to this block
  function automatic logic isMapped(input logic [7:0] idx);
    case (idx)
      gpio_monitor_pkg::IDX_MULTI_CFG,
      gpio_monitor_pkg::IDX_OUT_CFG,
      gpio_monitor_pkg::IDX_OUT_VALUE,
      gpio_monitor_pkg::IDX_PIN_MON,
      gpio_monitor_pkg::IDX_IN_CFG,
      gpio_monitor_pkg::IDX_IN_MON: isMapped = 1'b1;
      default: isMapped = 1'b0;
    endcase
  endfunction

  // level of the first pin that carries a routed function;
  // the multi-function pin wins, then the first and second input pins
  function automatic logic routeLevel(
    input logic [3:0] multiFn,
    input logic [2:0] firstFn,
    input logic [2:0] secondFn,
    input logic [gpio_monitor_pkg::PIN_COUNT-1:0] level,
    input logic [3:0] multiCode,
    input logic [2:0] inCode
  );
    if (multiFn == multiCode) begin
      routeLevel = level[gpio_monitor_pkg::PIN_MULTI];
    end else if (firstFn == inCode) begin
      routeLevel = level[gpio_monitor_pkg::PIN_FIRST];
    end else if (secondFn == inCode) begin
      routeLevel = level[gpio_monitor_pkg::PIN_SECOND];
    end else begin
      routeLevel = 1'b0;
    end
  endfunction

  // asynchronous board pins enter here and nowhere else
  assign pinRaw[gpio_monitor_pkg::PIN_MULTI] = multiPinIn;
  assign pinRaw[gpio_monitor_pkg::PIN_FIRST] = sharedAnalogInPin;
  assign pinRaw[gpio_monitor_pkg::PIN_SECOND] = micBiasPinIn;

  pin_sync u_pin_sync (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .pinRaw(pinRaw),
    .pinSync(pinLevel)
  );

  assign regIndex = {2'h0, paddr[gpio_monitor_pkg::ADDR_W-1:2]};
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped = aligned && isMapped(regIndex);
  assign setupPhase = psel && !penable;
  assign accessDone = psel && penable && pready;
  assign writeLow = accessDone && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[gpio_monitor_pkg::REG_W-1:0];

  // read image; reserved positions are constant zero
  always_comb begin
    readByte = '0;
    case (regIndex)
      gpio_monitor_pkg::IDX_MULTI_CFG: begin
        readByte[gpio_monitor_pkg::FN_HI:gpio_monitor_pkg::FN_LO] =
          multiPinFunction;
      end
      gpio_monitor_pkg::IDX_OUT_CFG: begin
        readByte[gpio_monitor_pkg::FN_HI:gpio_monitor_pkg::FN_LO] =
          outputPinFunction;
      end
      gpio_monitor_pkg::IDX_OUT_VALUE: begin
        readByte[gpio_monitor_pkg::MULTI_VAL_BIT] = multiPinOutLevel;
        readByte[gpio_monitor_pkg::OUT_VAL_BIT] = outputPinOutLevel;
      end
      gpio_monitor_pkg::IDX_PIN_MON: begin
        readByte[gpio_monitor_pkg::MULTI_MON_BIT] = multiPinInLevel; // R3
      end
      gpio_monitor_pkg::IDX_IN_CFG: begin
        readByte[gpio_monitor_pkg::FIRST_FN_HI:
                 gpio_monitor_pkg::FIRST_FN_LO] = firstInputPinFunction;
        readByte[gpio_monitor_pkg::SECOND_FN_HI:
                 gpio_monitor_pkg::SECOND_FN_LO] = secondInputPinFunction;
      end
      gpio_monitor_pkg::IDX_IN_MON: begin
        readByte[gpio_monitor_pkg::FIRST_MON_BIT] = firstInputPinLevel;
        readByte[gpio_monitor_pkg::SECOND_MON_BIT] = secondInputPinLevel;
      end
      default: readByte = '0; // R10
    endcase
  end

  // zero-wait slave: answer is prepared during the setup cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= setupPhase;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pslverr <= !mapped;
    end else if (accessDone) begin
      pslverr <= 1'b0;
    end
  end

  // upper bits and reserved bits always read as zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= '0;
    end else if (setupPhase && !pwrite && mapped) begin
      prdata <= {{(gpio_monitor_pkg::DATA_W-gpio_monitor_pkg::REG_W){1'b0}},
                 readByte}; // R10
    end else if (accessDone) begin
      prdata <= '0;
    end
  end

  // multi-function pin function field; drive field is not kept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiPinFunction <= gpio_monitor_pkg::MULTI_FN_RESET;
    end else if (writeLow && regIndex == gpio_monitor_pkg::IDX_MULTI_CFG) begin
      multiPinFunction <=
        wbyte[gpio_monitor_pkg::FN_HI:gpio_monitor_pkg::FN_LO];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      outputPinFunction <= gpio_monitor_pkg::OUT_FN_RESET;
    end else if (writeLow && regIndex == gpio_monitor_pkg::IDX_OUT_CFG) begin
      outputPinFunction <=
        wbyte[gpio_monitor_pkg::FN_HI:gpio_monitor_pkg::FN_LO];
    end
  end

  // output value bits; the low six bits are dropped on write
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiPinOutLevel <= gpio_monitor_pkg::VALUE_RESET; // R11
      outputPinOutLevel <= gpio_monitor_pkg::VALUE_RESET; // R11
    end else if (writeLow && regIndex == gpio_monitor_pkg::IDX_OUT_VALUE) begin
      multiPinOutLevel <= wbyte[gpio_monitor_pkg::MULTI_VAL_BIT];
      outputPinOutLevel <= wbyte[gpio_monitor_pkg::OUT_VAL_BIT];
    end
  end

  // input-only pin function fields
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      firstInputPinFunction <= gpio_monitor_pkg::IN_FN_RESET; // R11
      secondInputPinFunction <= gpio_monitor_pkg::IN_FN_RESET; // R11
    end else if (writeLow && regIndex == gpio_monitor_pkg::IDX_IN_CFG) begin
      firstInputPinFunction <= wbyte[gpio_monitor_pkg::FIRST_FN_HI:
                                     gpio_monitor_pkg::FIRST_FN_LO]; // R4
      secondInputPinFunction <= wbyte[gpio_monitor_pkg::SECOND_FN_HI:
                                      gpio_monitor_pkg::SECOND_FN_LO]; // R5
    end
  end

  // multi-function pin drive; only code 1 turns the driver on
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiPinOut <= 1'b0;
      multiPinOe <= 1'b0;
    end else begin
      multiPinOe <= (multiPinFunction == gpio_monitor_pkg::MF_GPO); // R12
      multiPinOut <= (multiPinFunction == gpio_monitor_pkg::MF_GPO) &&
                     multiPinOutLevel; // R1
    end
  end

  // output-only pin; disabled or unsupported codes leave it floating
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      outputPinOut <= 1'b0;
      outputPinOe <= 1'b0;
    end else begin
      outputPinOe <= (outputPinFunction == gpio_monitor_pkg::MF_GPO); // R13
      outputPinOut <= (outputPinFunction == gpio_monitor_pkg::MF_GPO) &&
                      outputPinOutLevel; // R2
    end
  end

  // monitors read zero unless the pin is set up as a general input
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiPinInLevel <= 1'b0;
    end else begin
      multiPinInLevel <= (multiPinFunction == gpio_monitor_pkg::MF_GPI) &&
                         pinLevel[gpio_monitor_pkg::PIN_MULTI]; // R12
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      firstInputPinLevel <= 1'b0;
    end else begin
      firstInputPinLevel <=
        (firstInputPinFunction == gpio_monitor_pkg::IN_GPI) &&
        pinLevel[gpio_monitor_pkg::PIN_FIRST]; // R8
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      secondInputPinLevel <= 1'b0;
    end else begin
      secondInputPinLevel <=
        (secondInputPinFunction == gpio_monitor_pkg::IN_GPI) &&
        pinLevel[gpio_monitor_pkg::PIN_SECOND]; // R9
    end
  end

  // routed functions; the reserved input code matches nothing here
  always_comb begin
    next_masterClockIn = routeLevel(multiPinFunction, firstInputPinFunction,
      secondInputPinFunction, pinLevel, gpio_monitor_pkg::MF_MCLK,
      gpio_monitor_pkg::IN_MCLK); // R4
    next_serialAudioChainInput = routeLevel(multiPinFunction,
      firstInputPinFunction, secondInputPinFunction, pinLevel,
      gpio_monitor_pkg::MF_SERIAL_AUDIO_CHAIN_INPUT, gpio_monitor_pkg::IN_SERIAL_AUDIO_CHAIN_INPUT); // R4
    next_pdmDataInCh12 = routeLevel(multiPinFunction, firstInputPinFunction,
      secondInputPinFunction, pinLevel, gpio_monitor_pkg::MF_PDM12,
      gpio_monitor_pkg::IN_PDM12); // R5
    next_pdmDataInCh34 = routeLevel(multiPinFunction, firstInputPinFunction,
      secondInputPinFunction, pinLevel, gpio_monitor_pkg::MF_PDM34,
      gpio_monitor_pkg::IN_PDM34); // R5
    next_micBiasEnable = (multiPinFunction == gpio_monitor_pkg::MF_MICROPHONE_BIAS_PIN_EN)
      && pinLevel[gpio_monitor_pkg::PIN_MULTI];
    // any pin set to power-down can hold the channels off
    next_channelPowerDown =
      ((firstInputPinFunction == gpio_monitor_pkg::IN_POWER_DOWN) &&
       pinLevel[gpio_monitor_pkg::PIN_FIRST]) ||
      ((secondInputPinFunction == gpio_monitor_pkg::IN_POWER_DOWN) &&
       pinLevel[gpio_monitor_pkg::PIN_SECOND]) ||
      ((multiPinFunction == gpio_monitor_pkg::MF_POWER_DOWN) &&
       pinLevel[gpio_monitor_pkg::PIN_MULTI]); // R6
  end

  // sampled at the core clock: a fast master clock or pdm stream is
  // only passed faithfully below half the core rate
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      masterClockIn <= 1'b0;
    end else begin
      masterClockIn <= next_masterClockIn;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      serialAudioChainInput <= 1'b0;
    end else begin
      serialAudioChainInput <= next_serialAudioChainInput;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pdmDataInCh12 <= 1'b0;
    end else begin
      pdmDataInCh12 <= next_pdmDataInCh12;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pdmDataInCh34 <= 1'b0;
    end else begin
      pdmDataInCh34 <= next_pdmDataInCh34;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      channelPowerDown <= 1'b0;
    end else begin
      channelPowerDown <= next_channelPowerDown; // R6
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      micBiasEnable <= 1'b0;
    end else begin
      micBiasEnable <= next_micBiasEnable;
    end
  end
endmodule // audio_adc_gpio_value_monitor

// [design/gpio_monitor_pkg.sv]
// How it works
// R1 - multi-function pin in output mode drives bit 7 of the output value register.
// R2 - output-only pin in output mode drives bit 6 of the output value register.
// R3 - multi-function pin in input mode reads back as bit 7 at 0x2A.
// R4 - first input-only pin function comes from bits 6-4 at 0x2B.
// R5 - second input-only pin function comes from bits 2-0 at 0x2B.
// R6 - function code 7 on an input-only pin makes it a channel power-down control.
// R7 - software never writes reserved code 6 into an input pin function field.
// R8 - first input-only pin level shows in bit 7 at 0x2F in input mode.
// R9 - microphone bias pin level shows in bit 6 at 0x2F in input mode.
// R10 - reserved bits are written as zero and always read back as zero.
// R11 - input pin functions and both output value bits reset to zero.
// R12 - multi-function pin is an output for code 1 and an input for code 9.
// R13 - output-only pin is an output for code 1; code 0 disables it.
// R14 - pin levels pass a two-stage synchronizer before reaching the monitors.
package gpio_monitor_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PIN_COUNT = 3;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_MULTI_CFG = 8'h21;
  localparam logic [7:0] IDX_OUT_CFG = 8'h22;
  localparam logic [7:0] IDX_OUT_VALUE = 8'h29;
  localparam logic [7:0] IDX_PIN_MON = 8'h2A;
  localparam logic [7:0] IDX_IN_CFG = 8'h2B;
  localparam logic [7:0] IDX_IN_MON = 8'h2F;
  // field positions
  localparam int FN_HI = 7;
  localparam int FN_LO = 4;
  localparam int MULTI_VAL_BIT = 7;
  localparam int OUT_VAL_BIT = 6;
  localparam int MULTI_MON_BIT = 7;
  localparam int FIRST_FN_HI = 6;
  localparam int FIRST_FN_LO = 4;
  localparam int SECOND_FN_HI = 2;
  localparam int SECOND_FN_LO = 0;
  localparam int FIRST_MON_BIT = 7;
  localparam int SECOND_MON_BIT = 6;
  // pin vector positions
  localparam int PIN_MULTI = 0;
  localparam int PIN_FIRST = 1;
  localparam int PIN_SECOND = 2;
  // reset values
  localparam logic [3:0] MULTI_FN_RESET = 4'h2;
  localparam logic [3:0] OUT_FN_RESET = 4'h0;
  localparam logic [2:0] IN_FN_RESET = 3'h0;
  localparam logic VALUE_RESET = 1'h0;
  // multi-function and output-only pin codes
  localparam logic [3:0] MF_DISABLED = 4'h0;
  localparam logic [3:0] MF_GPO = 4'h1;
  localparam logic [3:0] MF_POWER_DOWN = 4'h7;
  localparam logic [3:0] MF_MICROPHONE_BIAS_PIN_EN = 4'h8;
  localparam logic [3:0] MF_GPI = 4'h9;
  localparam logic [3:0] MF_MCLK = 4'hA;
  localparam logic [3:0] MF_SERIAL_AUDIO_CHAIN_INPUT = 4'hB;
  localparam logic [3:0] MF_PDM12 = 4'hC;
  localparam logic [3:0] MF_PDM34 = 4'hD;
  // input-only pin codes
  localparam logic [2:0] IN_DISABLED = 3'h0;
  localparam logic [2:0] IN_GPI = 3'h1;
  localparam logic [2:0] IN_MCLK = 3'h2;
  localparam logic [2:0] IN_SERIAL_AUDIO_CHAIN_INPUT = 3'h3;
  localparam logic [2:0] IN_PDM12 = 3'h4;
  localparam logic [2:0] IN_PDM34 = 3'h5;
  localparam logic [2:0] IN_RESERVED = 3'h6;
  localparam logic [2:0] IN_POWER_DOWN = 3'h7;
endpackage

// [design/pin_sync.sv]
`timescale 1ns/100ps
module pin_sync (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [gpio_monitor_pkg::PIN_COUNT-1:0] pinRaw,
  output logic [gpio_monitor_pkg::PIN_COUNT-1:0] pinSync
);
  // first stage is read only by the second
  logic [gpio_monitor_pkg::PIN_COUNT-1:0] stageOne;

  genvar i;
  generate
    for (i = 0; i < gpio_monitor_pkg::PIN_COUNT; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          stageOne[i] <= 1'b0;
          pinSync[i] <= 1'b0;
        end else begin
          stageOne[i] <= pinRaw[i]; // R14
          pinSync[i] <= stageOne[i]; // R14
        end
      end
    end
  endgenerate
endmodule // pin_sync

// [tb/audio_adc_gpio_value_monitor_asserts.sv]
`timescale 1ns/100ps
module audio_adc_gpio_value_monitor_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic multiPinOut,
  input wire logic multiPinOe,
  input wire logic outputPinOut,
  input wire logic outputPinOe,
  input wire logic channelPowerDown
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence
  sequence s_rd(a);
    psel && penable && pready && !pwrite && paddr == a;
  endsequence
  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_in_access: assert property (
    pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  chk_multi_dir: assert property (
    s_wr(8'h84) |=> ##1 multiPinOe == ($past(pwdata[7:4], 2) == 4'h1))
    else $error("multi pin enable wrong");
  chk_output_dir: assert property (
    s_wr(8'h88) |=> ##1 outputPinOe == ($past(pwdata[7:4], 2) == 4'h1))
    else $error("output pin enable wrong");
  chk_multi_level: assert property (
    s_wr(8'hA4) |=> ##1 !multiPinOe || multiPinOut == $past(pwdata[7], 2))
    else $error("multi pin level wrong");
  chk_output_level: assert property (
    s_wr(8'hA4) |=> ##1 !outputPinOe || outputPinOut == $past(pwdata[6], 2))
    else $error("output pin level wrong");
  chk_cfg_reserved: assert property (
    s_rd(8'hAC) |-> prdata[7] == 1'b0 && prdata[3] == 1'b0)
    else $error("config reserved bits set");
  chk_mon_reserved: assert property (
    s_rd(8'hA8) |-> prdata[6:0] == 7'h00)
    else $error("pin monitor reserved bits set");
  chk_reset_idle: assert property (
    $rose(arst_n) |-> !multiPinOe && !outputPinOe && !channelPowerDown)
    else $error("outputs active after reset");
  chk_bad_addr: assert property (
    pready && (paddr[1:0] != 2'h0 || paddr == 8'h00) |-> pslverr
      && prdata == 32'h0)
    else $error("bad address not refused");
endmodule // audio_adc_gpio_value_monitor_asserts

// [tb/audio_adc_gpio_value_monitor_tb.sv]
`timescale 1ns/100ps
module audio_adc_gpio_value_monitor_tb;
  logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rerr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdata, prdata;
  logic [3:0] pstrb = 4'hF;
  logic [2:0] boardLevel = 3'h0;
  logic pready, pslverr, multiPinIn, multiPinOut, multiPinOe, outputPinOut;
  logic outputPinOe, sharedAnalogInPin, micBiasPinIn, masterClockIn;
  logic serialAudioChainInput, pdmDataInCh12, pdmDataInCh34;
  logic channelPowerDown, micBiasEnable;
  int err_count = 0;
  int total_checks = 0;
  wire [4:0] routed = {channelPowerDown, masterClockIn,
    serialAudioChainInput, pdmDataInCh12, pdmDataInCh34};
  wire [3:0] drive = {multiPinOe, multiPinOut, outputPinOe, outputPinOut};
  // first fn, second fn, {second,first,multi} levels, monitor, routed
  typedef struct packed {
    logic [2:0] fn1, fn2, lvl;
    logic [7:0] mon;
    logic [4:0] pins;
  } row_t;
  row_t rows [9] = '{'{3'h1, 3'h1, 3'h2, 8'h80, 5'h00},
    '{3'h1, 3'h1, 3'h4, 8'h40, 5'h00}, '{3'h0, 3'h0, 3'h6, 8'h00, 5'h00},
    '{3'h2, 3'h3, 3'h6, 8'h00, 5'h0C}, '{3'h4, 3'h5, 3'h2, 8'h00, 5'h02},
    '{3'h5, 3'h4, 3'h2, 8'h00, 5'h01}, '{3'h7, 3'h0, 3'h2, 8'h00, 5'h10},
    '{3'h0, 3'h7, 3'h4, 8'h00, 5'h10}, '{3'h0, 3'h7, 3'h0, 8'h00, 5'h00}};

  audio_adc_gpio_value_monitor u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .multiPinIn(multiPinIn), .multiPinOut(multiPinOut),
    .multiPinOe(multiPinOe), .outputPinOut(outputPinOut),
    .outputPinOe(outputPinOe), .sharedAnalogInPin(sharedAnalogInPin),
    .micBiasPinIn(micBiasPinIn), .masterClockIn(masterClockIn),
    .serialAudioChainInput(serialAudioChainInput),
    .pdmDataInCh12(pdmDataInCh12), .pdmDataInCh34(pdmDataInCh34),
    .channelPowerDown(channelPowerDown), .micBiasEnable(micBiasEnable));
  gpio_board_model u_board (.multiPinOut(multiPinOut),
    .multiPinOe(multiPinOe), .boardLevel(boardLevel),
    .multiPinIn(multiPinIn), .sharedAnalogInPin(sharedAnalogInPin),
    .micBiasPinIn(micBiasPinIn));

  always #25 core_clk = ~core_clk;

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      err_count++;
      final_report();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(rdata, {24'h0, e});
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(8'hAC, 8'h00);
    rd(8'hA4, 8'h00);
    rd(8'hA8, 8'h00);
    rd(8'hBC, 8'h00);
    rd(8'h84, 8'h20);
    rd(8'h88, 8'h00);
    foreach (rows[k]) begin
      wr(8'hAC, {1'b0, rows[k].fn1, 1'b0, rows[k].fn2});
      boardLevel <= rows[k].lvl;
      repeat (4) @(posedge core_clk);
      chk({27'h0, routed}, {27'h0, rows[k].pins});
      rd(8'hBC, rows[k].mon);
      rd(8'hAC, {1'b0, rows[k].fn1, 1'b0, rows[k].fn2});
    end
    wr(8'h84, 8'h10);
    wr(8'h88, 8'h10);
    wr(8'hA4, 8'hC0);
    repeat (2) @(posedge core_clk);
    chk({28'h0, drive}, 32'hF);
    rd(8'hA4, 8'hC0);
    rd(8'hA8, 8'h00);
    wr(8'hA4, 8'h40);
    repeat (2) @(posedge core_clk);
    chk({28'h0, drive}, 32'hB);
    wr(8'h84, 8'h90);
    wr(8'h88, 8'h00);
    boardLevel <= 3'h1;
    repeat (4) @(posedge core_clk);
    chk({30'h0, multiPinOe, outputPinOe}, 32'h0);
    rd(8'hA8, 8'h80);
    boardLevel <= 3'h4;
    repeat (4) @(posedge core_clk);
    rd(8'hA8, 8'h00);
    // error flag lands in bit 0, read data bits 30-0 must stay zero
    apb(1'b0, 8'h00, 32'h0, 4'hF);
    chk({rdata[30:0], rerr}, 32'h1);
    apb(1'b0, 8'hAD, 32'h0, 4'hF);
    chk({rdata[30:0], rerr}, 32'h1);
    apb(1'b1, 8'hAC, 32'h11, 4'h0);
    rd(8'hAC, 8'h07);
    wr(8'hBC, 8'hC0);
    chk({31'h0, rerr}, 32'h0);
    rd(8'hBC, 8'h00);
    chk({31'h0, channelPowerDown}, 32'h1);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({27'h0, drive, channelPowerDown}, 32'h0);
    arst_n <= 1'b1;
    rd(8'hAC, 8'h00);
    rd(8'hA4, 8'h00);
    // multi pin routes: mic bias enable, clock priority, power-down
    boardLevel <= 3'h1;
    wr(8'h84, 8'h80);
    repeat (4) @(posedge core_clk);
    chk({31'h0, micBiasEnable}, 32'h1);
    wr(8'h84, 8'hA0);
    wr(8'hAC, 8'h20);
    repeat (4) @(posedge core_clk);
    chk({27'h0, routed}, 32'h08);
    wr(8'h84, 8'h70);
    repeat (4) @(posedge core_clk);
    chk({27'h0, routed}, 32'h10);
    final_report();
  end
endmodule // audio_adc_gpio_value_monitor_tb

bind audio_adc_gpio_value_monitor audio_adc_gpio_value_monitor_asserts u_chk (
  .core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .multiPinOut(multiPinOut), .multiPinOe(multiPinOe),
  .outputPinOut(outputPinOut), .outputPinOe(outputPinOe),
  .channelPowerDown(channelPowerDown));

// [tb/gpio_board_model.sv]
`timescale 1ns/100ps
module gpio_board_model (
  input wire logic multiPinOut,
  input wire logic multiPinOe,
  input wire logic [2:0] boardLevel,
  output logic multiPinIn,
  output logic sharedAnalogInPin,
  output logic micBiasPinIn
);
  // board lets go of the shared wire while the device drives it
  assign multiPinIn = multiPinOe ? multiPinOut : boardLevel[0];
  assign sharedAnalogInPin = boardLevel[1];
  assign micBiasPinIn = boardLevel[2];
endmodule // gpio_board_model
